/* File: hw/fetch_pkg.sv */
package fetch_pkg;
	localparam int PC_W = 21;
	localparam int SP_W = 5;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [20:0] RESET_VECTOR = 21'h000000;
	localparam logic [20:0] VEC_HIGH_PRIO = 21'h000008;
	localparam logic [20:0] VEC_LOW_PRIO = 21'h000018;
	localparam logic [20:0] INSTR_STEP = 21'h000002;
	localparam logic [20:0] LIMIT_48K = 21'h00bfff;
	localparam logic [20:0] LIMIT_64K = 21'h00ffff;
	localparam logic [4:0] SP_RESET = 5'h00;
	localparam logic [4:0] SP_FULL = 5'h1f;
	localparam logic [15:0] NOP_WORD = 16'h0000;
	localparam logic [20:0] STACK_EMPTY_WORD = 21'h000000;
	localparam int UPPER_LSB = 16;
	localparam int HIGH_LSB = 8;
	localparam int LOW_LSB = 0;
endpackage

/* File: hw/program_fetch_vectoring.sv */
`timescale 1ns/1ns
// What this block does
// - program counter is 21 bits, 2-Mbyte space
// - fetch above present memory returns zero
// - present memory is 48K or 64K by variant
// - any reset starts fetching at 0000h
// - two fixed interrupt vectors 0008h and 0018h
// - interrupt wake with enable loads vector
// - interrupt wake pushes pc, advances pointer, unless the stack is full
// - wake-up sets cause flag bits
// - program fetch bus separate from data
// - push increments pointer, then writes entry
module program_fetch_vectoring (
	input wire logic clk, // core clock, 100 MHz
	input wire logic rstn, // synchronous reset, active low
	input wire logic variant_64k, // 1: 64 Kbyte flash, 0: 48 Kbyte
	input wire logic advance, // step pc to next instruction
	input wire logic branch, // load pc from branch_addr
	input wire logic [20:0] branch_addr, // branch target
	input wire logic ret_pop, // return: pop pc from stack
	input wire logic wake_irq, // wake-up caused by interrupt
	input wire logic wake_wdt, // wake-up caused by watchdog
	input wire logic irq_high, // pending interrupt is high priority
	input wire logic global_irq_enable_low, // low global enable
	input wire logic global_irq_enable_high, // high global enable
	input wire logic flag_clear, // clear wake cause flags
	input wire logic [15:0] flash_rdata, // flash word, one cycle after address
	output logic [20:0] flash_addr, // flash fetch address
	output logic flash_rd, // flash fetch strobe
	output logic [20:0] pc, // program counter
	output logic [15:0] instr, // fetched instruction word
	output logic [20:0] instr_addr, // address of instr
	output logic instr_valid, // instr holds a fetched word
	output logic [7:0] stack_top_upper_byte, // top of stack bits 20:16
	output logic [7:0] stack_top_high_byte, // top of stack bits 15:8
	output logic [7:0] stack_top_low_byte, // top of stack bits 7:0
	output logic [4:0] return_stack_pointer, // stack pointer
	output logic irq_control_regs, // wake by interrupt flag
	output logic peripheral_irq_flag_regs // wake by watchdog flag
);
	typedef struct packed {
		logic [20:0] pc;
		logic [4:0] sp;
		logic run;
		logic p1_valid;
		logic p1_zero;
		logic [20:0] p1_addr;
		logic [15:0] instr;
		logic instr_valid;
		logic [20:0] instr_addr;
		logic wake_irq_flag;
		logic wake_wdt_flag;
	} state_t;

	state_t s;
	state_t next_s;
	logic take;
	stack_port_if st ();
	logic [20:0] top_word;

	function automatic logic [20:0] flash_limit(input logic big);
		return big ? fetch_pkg::LIMIT_64K : fetch_pkg::LIMIT_48K;
	endfunction

	function automatic logic above_flash(input logic [20:0] addr, input logic big);
		return addr > flash_limit(big);
	endfunction

	return_stack_ram u_ram (
		.clk(clk),
		.port(st.ram)
	);

	always_comb begin
		next_s = s;
		take = rstn && wake_irq && (global_irq_enable_low || global_irq_enable_high);
		st.we = 1'b0;
		st.wr_addr = 5'(s.sp + 5'h01);
		st.wr_data = s.pc;
		if (take) begin
			// a full stack keeps its last entry; vectoring still happens
			if (s.sp != fetch_pkg::SP_FULL) begin
				next_s.sp = 5'(s.sp + 5'h01);
				st.we = 1'b1;
			end
			next_s.pc = irq_high ? fetch_pkg::VEC_HIGH_PRIO : fetch_pkg::VEC_LOW_PRIO;
		end else if (ret_pop) begin
			next_s.pc = st.rd_data;
			if (s.sp != fetch_pkg::SP_RESET) begin
				next_s.sp = 5'(s.sp - 5'h01);
			end
		end else if (branch) begin
			next_s.pc = branch_addr;
		end else if (advance) begin
			next_s.pc = 21'(s.pc + fetch_pkg::INSTR_STEP);
		end
		// set wins over clear
		next_s.wake_irq_flag = wake_irq | (s.wake_irq_flag & ~flag_clear);
		next_s.wake_wdt_flag = wake_wdt | (s.wake_wdt_flag & ~flag_clear);
		next_s.run = 1'b1;
		// fetch path never waits on data memory, so it issues every cycle
		next_s.p1_valid = s.run;
		next_s.p1_addr = s.pc;
		next_s.p1_zero = above_flash(s.pc, variant_64k);
		next_s.instr_valid = s.p1_valid;
		next_s.instr_addr = s.p1_addr;
		next_s.instr = s.p1_zero ? fetch_pkg::NOP_WORD : flash_rdata;
		// reading at the next pointer keeps top-of-stack coherent after push or pop
		st.rd_addr = rstn ? next_s.sp : fetch_pkg::SP_RESET;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
			s.pc <= fetch_pkg::RESET_VECTOR;
			s.sp <= fetch_pkg::SP_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign pc = s.pc;
	assign flash_addr = s.pc;
	assign flash_rd = s.run;
	assign instr = s.instr;
	assign instr_addr = s.instr_addr;
	assign instr_valid = s.instr_valid;
	assign return_stack_pointer = s.sp;
	assign irq_control_regs = s.wake_irq_flag;
	assign peripheral_irq_flag_regs = s.wake_wdt_flag;
	assign stack_top_upper_byte = 8'(st.rd_data[20:fetch_pkg::UPPER_LSB]);
	assign stack_top_high_byte = st.rd_data[fetch_pkg::UPPER_LSB - 1:fetch_pkg::HIGH_LSB];
	assign stack_top_low_byte = st.rd_data[fetch_pkg::HIGH_LSB - 1:fetch_pkg::LOW_LSB];
	assign top_word = {stack_top_upper_byte[4:0], stack_top_high_byte, stack_top_low_byte};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// control checks look one edge on; priority is take, pop, branch, advance
	sequence seq_plain_step;
		advance && !branch && !ret_pop && !take;
	endsequence

	sequence seq_branch_only;
		branch && !ret_pop && !take;
	endsequence

	sequence seq_pop_only;
		ret_pop && !take;
	endsequence

	sequence seq_issue_above;
		s.run && pc > (variant_64k ? fetch_pkg::LIMIT_64K : fetch_pkg::LIMIT_48K);
	endsequence

	sequence seq_irq_push;
		take && return_stack_pointer != fetch_pkg::SP_FULL;
	endsequence

	sequence seq_push_full;
		take && return_stack_pointer == fetch_pkg::SP_FULL;
	endsequence

	chk_pc_step_wrap: assert property (seq_plain_step |=> pc == 21'($past(pc) + fetch_pkg::INSTR_STEP))
		else $error("pc did not step by two within 21 bits");

	chk_branch_load: assert property (seq_branch_only |=> pc == $past(branch_addr))
		else $error("branch target not loaded into pc");

	chk_zero_above_flash: assert property (
		seq_issue_above ##1 s.p1_valid |=> instr_valid && instr == fetch_pkg::NOP_WORD)
		else $error("fetch above flash did not return zero");

	chk_fetch_in_flash: assert property (s.p1_valid && !s.p1_zero |=> instr == $past(flash_rdata))
		else $error("fetch inside flash did not pass the flash word");

	// the limit is judged with the variant seen when the address was issued
	chk_limit_by_variant: assert property (
		s.p1_valid |-> s.p1_zero == (s.p1_addr > ($past(variant_64k) ? fetch_pkg::LIMIT_64K : fetch_pkg::LIMIT_48K)))
		else $error("flash limit does not match variant");

	chk_reset_vector: assert property (
		disable iff (1'b0) !rstn |=> pc == fetch_pkg::RESET_VECTOR && return_stack_pointer == fetch_pkg::SP_RESET)
		else $error("reset did not load reset vector");

	chk_reset_outputs: assert property (
		disable iff (1'b0) !rstn |=> !flash_rd && !instr_valid && !irq_control_regs && !peripheral_irq_flag_regs)
		else $error("reset left fetch or wake flags active");

	chk_vector_target: assert property (
		take |=> (pc == fetch_pkg::VEC_HIGH_PRIO && $past(irq_high)) || (pc == fetch_pkg::VEC_LOW_PRIO && !$past(irq_high)))
		else $error("interrupt vector wrong for priority");

	chk_no_vector_disabled: assert property (
		wake_irq && !global_irq_enable_low && !global_irq_enable_high && !ret_pop && !branch && !advance
		|=> pc == $past(pc))
		else $error("pc vectored with both enables clear");

	chk_push_saves_pc: assert property (
		seq_irq_push |=> return_stack_pointer == 5'($past(return_stack_pointer) + 5'h01) && top_word == $past(pc))
		else $error("interrupt push did not save pc");

	// a dropped push must not disturb the last saved return address
	chk_full_keeps_top: assert property (
		seq_push_full |=> return_stack_pointer == fetch_pkg::SP_FULL && top_word == $past(top_word))
		else $error("push on a full stack changed the top entry");

	chk_pop_restores: assert property (seq_pop_only |=> pc == $past(top_word))
		else $error("return did not restore the saved pc");

	chk_pop_pointer: assert property (
		seq_pop_only ##0 return_stack_pointer != fetch_pkg::SP_RESET
		|=> return_stack_pointer == 5'($past(return_stack_pointer) - 5'h01))
		else $error("return did not step the stack pointer down");

	chk_wake_cause_flag: assert property (
		(wake_irq |=> irq_control_regs) and (wake_wdt |=> peripheral_irq_flag_regs))
		else $error("wake-up cause flag not set");

	chk_flag_clear: assert property (
		flag_clear && !wake_irq && !wake_wdt |=> !irq_control_regs && !peripheral_irq_flag_regs)
		else $error("wake flags survived a clear");

	chk_fetch_every_cycle: assert property (s.run |-> flash_rd ##1 s.p1_valid && s.p1_addr == $past(pc))
		else $error("fetch stalled or lost its address");

	chk_instr_pipeline: assert property (s.p1_valid |=> instr_valid && instr_addr == $past(s.p1_addr))
		else $error("fetched word lost its address");

	chk_push_order: assert property (
		st.we |-> st.wr_addr == 5'(return_stack_pointer + 5'h01) && st.rd_addr == st.wr_addr)
		else $error("push wrote entry other than incremented pointer");
endmodule // program_fetch_vectoring

/* File: hw/return_stack_ram.sv */
`timescale 1ns/1ns
module return_stack_ram (
	input wire logic clk, // core clock
	stack_port_if.ram port // write and read port
);
	logic [20:0] mem [1:31];

	// entry zero has no storage; reading it gives zero so an underflow pop lands on the reset vector
	always_ff @(posedge clk) begin
		if (port.we && port.wr_addr != fetch_pkg::SP_RESET) begin
			mem[port.wr_addr] <= port.wr_data;
		end
		if (port.rd_addr == fetch_pkg::SP_RESET) begin
			port.rd_data <= fetch_pkg::STACK_EMPTY_WORD;
		end else if (port.we && port.wr_addr == port.rd_addr) begin
			port.rd_data <= port.wr_data;
		end else begin
			port.rd_data <= mem[port.rd_addr];
		end
	end
endmodule // return_stack_ram

/* File: hw/stack_port_if.sv */
`timescale 1ns/1ns
interface stack_port_if;
	logic we;
	logic [4:0] wr_addr;
	logic [20:0] wr_data;
	logic [4:0] rd_addr;
	logic [20:0] rd_data;
	modport ctrl (output we, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport ram (input we, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* File: test/flash_model.sv */
`timescale 1ns/1ns
module flash_model (
	input wire logic clk, // core clock
	input wire logic rd, // fetch strobe
	input wire logic [20:0] addr, // byte address
	output logic [15:0] rdata // word, one cycle later
);
	initial rdata = 16'h0000;
	// idle bus toggles so a stale word never passes for data
	always @(posedge clk) rdata <= rd ? (addr[16:1] ^ 16'h5a3c) : ~rdata;
endmodule // flash_model

/* File: test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	logic clk = 0, rstn = 0, v64 = 0, adv = 0, br = 0, pop = 0, wi = 0, ww = 0, ih = 0, gl = 0, gh = 0, fc = 0;
	logic [20:0] ba = 0, a, fa, pc, ia, fa1, fa2;
	logic [15:0] fd, ins;
	logic [7:0] tu, th, tl;
	logic [4:0] sp;
	logic fr, iv, fi, fp;
	int num_errors = 0, n_checks = 0, seed = 32'h20b5c60e;
	typedef struct {logic [20:0] pc; logic [4:0] sp; logic [20:0] tos; logic [1:0] fl;} note_t;
	note_t q[$];
	event res;
	always #5 clk = ~clk;
	program_fetch_vectoring i_dut (.clk(clk), .rstn(rstn), .variant_64k(v64), .advance(adv), .branch(br),
		.branch_addr(ba), .ret_pop(pop), .wake_irq(wi), .wake_wdt(ww), .irq_high(ih),
		.global_irq_enable_low(gl), .global_irq_enable_high(gh), .flag_clear(fc), .flash_rdata(fd),
		.flash_addr(fa), .flash_rd(fr), .pc(pc), .instr(ins), .instr_addr(ia), .instr_valid(iv),
		.stack_top_upper_byte(tu), .stack_top_high_byte(th), .stack_top_low_byte(tl),
		.return_stack_pointer(sp), .irq_control_regs(fi), .peripheral_irq_flag_regs(fp));
	flash_model i_flash (.clk(clk), .rd(fr), .addr(fa), .rdata(fd));
	task check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// control bits {branch, pop, wake_irq, wake_wdt, irq_high, flag_clear}; result read two edges on
	task step(logic [5:0] c, logic [20:0] t, logic [20:0] epc, logic [4:0] esp, logic [20:0] etos,
		logic [1:0] efl);
		{br, pop, wi, ww, ih, fc} = c;
		ba = t;
		@(posedge clk) #1 {br, pop, wi, ww, ih, fc} = 6'h00;
		@(posedge clk) #1 q.push_back('{epc, esp, etos, efl});
		->res;
	endtask
	always @(res) begin
		note_t n;
		n = q.pop_front();
		check("pc", pc, n.pc);
		check("sp", sp, n.sp);
		check("tos", {tu, th, tl}, n.tos);
		check("flags", {fi, fp}, n.fl);
	end
	// words above the present flash must read as zero whatever the bus carries
	function automatic logic [15:0] word_at(logic [20:0] ad, logic big);
		return ad > (big ? fetch_pkg::LIMIT_64K : fetch_pkg::LIMIT_48K) ? 16'h0000 : ad[16:1] ^ 16'h5a3c;
	endfunction
	// the word shown now was addressed two edges ago
	always @(posedge clk) begin
		fa1 <= fa;
		fa2 <= fa1;
	end
	always @(negedge clk) if (iv === 1'b1) begin
		check("instr", ins, word_at(ia, v64));
		check("instr_addr", ia, fa2);
		check("flash_rd", fr, 1'b1);
	end
	initial begin
		#100000;
		num_errors++;
		final_report;
	end
	initial begin
		repeat (2) @(posedge clk);
		#1 rstn = 1;
		step(6'h00, 0, 0, 0, 0, 0);
		adv = 1;
		step(6'h20, 21'h00bffa, 21'h00bffc, 0, 0, 0);
		repeat (6) @(posedge clk) #1;
		repeat (8) begin
			a = 21'($random(seed)) & 21'h01fffe;
			step(6'h20, a, a + 21'h2, 0, 0, 0);
			repeat (3) @(posedge clk) #1;
		end
		step(6'h20, 21'h1ffffe, 21'h000000, 0, 0, 0);
		adv = 0;
		step(6'h20, 21'h1ffffe, 21'h1ffffe, 0, 0, 0);
		gh = 1;
		step(6'h0a, 0, 21'h000008, 1, 21'h1ffffe, 2'h2);
		gh = 0;
		gl = 1;
		step(6'h08, 0, 21'h000018, 2, 21'h000008, 2'h2);
		step(6'h10, 0, 21'h000008, 1, 21'h1ffffe, 2'h2);
		step(6'h10, 0, 21'h1ffffe, 0, 0, 2'h2);
		gl = 0;
		step(6'h0c, 0, 21'h1ffffe, 0, 0, 2'h3);
		step(6'h05, 0, 21'h1ffffe, 0, 0, 2'h1);
		step(6'h01, 0, 21'h1ffffe, 0, 0, 2'h0);
		gh = 1;
		for (int i = 1; i < 32; i++) step(6'h0a, 0, 21'h000008, 5'(i), i == 1 ? 21'h1ffffe : 21'h000008, 2'h2);
		step(6'h20, 21'h000100, 21'h000100, 5'h1f, 21'h000008, 2'h2);
		step(6'h0a, 0, 21'h000008, 5'h1f, 21'h000008, 2'h2);
		gh = 0;
		rstn = 0;
		v64 = 1;
		repeat (2) @(posedge clk);
		#1 rstn = 1;
		step(6'h00, 0, 0, 0, 0, 0);
		adv = 1;
		step(6'h20, 21'h00fffa, 21'h00fffc, 0, 0, 0);
		repeat (6) @(posedge clk);
		final_report;
	end
endmodule // tb_top
